// ---- bench/wid_core_model.sv ----
// Core sequencer stand-in that records wake, resume and branch requests
`timescale 1ns/1ps
module wid_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Dispatch outputs
  input wire logic wake,
  input wire logic resume,
  input wire logic irq_valid,
  input wire logic [7:0] irq_vector,
  // Event record
  output logic [7:0] n_wake,
  output logic [7:0] n_resume,
  output logic [7:0] n_irq,
  output logic [7:0] last_vec
);
  // Pulses last one cycle, so every edge is counted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_wake <= 8'h00;
      n_resume <= 8'h00;
      n_irq <= 8'h00;
      last_vec <= 8'h00;
    end else begin
      if (wake) begin
        n_wake <= n_wake + 8'h01;
      end
      if (resume) begin
        n_resume <= n_resume + 8'h01;
      end
      if (irq_valid) begin
        n_irq <= n_irq + 8'h01;
        last_vec <= irq_vector;
      end
    end
  end
endmodule

// ---- bench/wid_dispatch_tb.sv ----
// Self-checking bench for the wake-up and interrupt dispatch block
`timescale 1ns/1ps
module wid_dispatch_tb;
  import wid_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, ext_int = 1'b0, timer_ovf = 1'b0, conv_done = 1'b0;
  logic [7:0] port_in = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000, rdata, rd_data;
  logic [39:0] r;
  logic [7:0] n_abort;
  logic sleeping, clk_run, conv_run, conv_abort, wake, resume, irq_valid;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] irq_vector, n_wake, n_resume, n_irq, last_vec;
  logic [1:0] bresp, rresp, rsp;
  int fails = 0, samples_checked = 0, cycles = 0;
  // Row: sleep,glb,src | wake en | irq en | flags | wake,resume | vector
  logic [39:0] rows [21] = '{
    40'h0_00_04_04_0_00, 40'h4_00_04_04_0_03, 40'h1_00_00_00_0_00, 40'h1_00_02_02_0_00,
    40'h5_00_02_02_0_06, 40'h2_00_01_01_0_00, 40'h6_00_01_01_0_09, 40'h3_00_00_00_0_00,
    40'h3_00_20_20_0_00, 40'h7_00_20_20_0_0C, 40'hC_00_04_00_0_00, 40'h9_00_00_00_0_00,
    40'h9_00_02_02_0_00, 40'h9_02_00_00_C_00, 40'h9_02_02_02_C_00, 40'hD_02_02_02_8_06,
    40'hB_00_00_00_0_00, 40'hB_00_20_20_0_00, 40'hB_08_00_00_C_00, 40'hB_08_20_20_C_00,
    40'hF_08_20_20_8_0C};

  wid_dispatch #(.PORT_W(8)) i_wid_dispatch (
    .CORE_CLK(core_clk), .RST(rst), .EXT_INT(ext_int), .PORT_IN(port_in), .TIMER_OVF(timer_ovf),
    .CONV_DONE(conv_done), .SLEEPING(sleeping), .CLK_RUN(clk_run), .CONV_RUN(conv_run),
    .CONV_ABORT(conv_abort), .WAKE(wake), .RESUME(resume), .IRQ_VALID(irq_valid),
    .IRQ_VECTOR(irq_vector), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1));

  wid_core_model i_wid_core_model (
    .clk(core_clk), .rst(rst), .wake(wake), .resume(resume), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .n_wake(n_wake), .n_resume(n_resume), .n_irq(n_irq),
    .last_vec(last_vec));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // Abort is a one-cycle pulse, so count it where it stands
  always @(posedge core_clk) begin
    if (rst) begin
      n_abort <= 8'h00;
    end else if (conv_abort) begin
      n_abort <= n_abort + 8'h01;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs about 570 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Response channels stay ready, so each task ends on its answer edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge core_clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge core_clk); while (!bvalid);
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rd_data = rdata;
    rsp = rresp;
  endtask

  task automatic rst_dut();
    rst <= 1'b1;
    ext_int <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic pulse_gap();
    @(posedge core_clk);
    timer_ovf <= 1'b0;
    conv_done <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    for (int i = 0; i < 21; i++) begin
      r = rows[i];
      rst_dut();
      wr(ADDR_CMD, {27'h0, r[37:36] == 2'd3, 1'b1, !r[38], r[38], 1'b0});
      wr(ADDR_WAKE_EN, {24'h0, r[35:28]});
      wr(ADDR_IRQ_EN, {24'h0, r[27:20]});
      if (r[39]) begin
        wr(ADDR_CMD, 32'h00000001);
      end
      repeat (2) @(posedge core_clk);
      chk("clk_run", {31'h0, !r[39] | r[31]}, {31'h0, clk_run});
      if (r[37:36] == 2'd3) begin
        chk("conv_run", {31'h0, !r[39] | r[31]}, {31'h0, conv_run});
      end
      case (r[37:36])
        2'd0: ext_int <= 1'b1;
        2'd1: port_in <= ~port_in;
        2'd2: timer_ovf <= 1'b1;
        default: conv_done <= 1'b1;
      endcase
      pulse_gap();
      rd(ADDR_FLAGS);
      chk("flags", {24'h0, r[19:12]}, rd_data & {24'h0, r[27:20]});
      rd(ADDR_STATUS);
      chk("asleep", {31'h0, r[39] & !r[11]}, {31'h0, rd_data[ST_ASLEEP]});
      chk("sleeping", {31'h0, r[39] & !r[11]}, {31'h0, sleeping});
      chk("conv_abort", {31'h0, r[39] & (r[37:36] == 2'd3) & !r[31]}, {24'h0, n_abort});
      chk("wake", {31'h0, r[11]}, {24'h0, n_wake});
      chk("resume", {31'h0, r[10]}, {24'h0, n_resume});
      chk("branch", {31'h0, r[7:0] != 8'h00}, {24'h0, n_irq});
      chk("vector", {24'h0, r[7:0]}, {24'h0, last_vec});
      $display("row %0d done", i);
    end
    // Reset values and refused addresses
    rst_dut();
    chk("vector reset", 32'h0, {24'h0, irq_vector});
    chk("clk_run reset", 32'h1, {31'h0, clk_run});
    rd(ADDR_IRQ_EN);
    chk("irq_en reset", 32'h0, rd_data);
    rd(8'h14);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd_data);
    wr(8'h14, 32'h000000FF);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd(ADDR_CMD);
    chk("cmd reads zero", 32'h0, rd_data);
    $display("reset test done");
    // Simultaneous events, held flags, selective clear
    rst_dut();
    wr(ADDR_CMD, 32'h0000000A);
    wr(ADDR_IRQ_EN, 32'h00000005);
    ext_int <= 1'b1;
    timer_ovf <= 1'b1;
    pulse_gap();
    chk("one branch", 32'h1, {24'h0, n_irq});
    chk("ext wins", {24'h0, VEC_EXT}, {24'h0, last_vec});
    timer_ovf <= 1'b1;
    pulse_gap();
    chk("timer vector", {24'h0, VEC_TOV}, {24'h0, irq_vector});
    rd(ADDR_FLAGS);
    chk("flags held", 32'h5, rd_data);
    wr(ADDR_FLAGS, 32'h00000004);
    rd(ADDR_FLAGS);
    chk("flag clear", 32'h1, rd_data);
    $display("overlap test done");
    test_done();
  end
endmodule

// ---- pkg/wid_chg_if.sv ----
// Link between dispatcher and port change detector
`timescale 1ns/1ps
interface wid_chg_if;
  logic snap;
  logic change;
  modport ctl (output snap, input change);
  modport det (input snap, output change);
endinterface

// ---- pkg/wid_pkg.sv ----
// Constants and types shared by the wake-up and interrupt dispatch block
package wid_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_IRQ_EN = 8'h00;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  // Enable and flag bit positions (flags share the enable positions)
  localparam int BIT_TOV = 0;
  localparam int BIT_CHG = 1;
  localparam int BIT_EXT = 2;
  localparam int BIT_CONV = 5;
  localparam int BIT_WAKE_CHG = 1;
  localparam int BIT_WAKE_CONV = 3;
  // Command bits, write-only pulses
  localparam int CMD_SLEEP = 0;
  localparam int CMD_GLB_ON = 1;
  localparam int CMD_GLB_OFF = 2;
  localparam int CMD_PORT_READ = 3;
  localparam int CMD_CONV_START = 4;
  // Status bit positions
  localparam int ST_ASLEEP = 0;
  localparam int ST_GLB = 1;
  localparam int ST_CONV_RUN = 2;
  localparam int ST_VEC_LSB = 8;
  // Interrupt vectors
  localparam logic [7:0] VEC_EXT = 8'h03;
  localparam logic [7:0] VEC_CHG = 8'h06;
  localparam logic [7:0] VEC_TOV = 8'h09;
  localparam logic [7:0] VEC_CONV = 8'h0C;
  // Reset values
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_VECTOR = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    WID_NORMAL = 1'b0,
    WID_SLEEP = 1'b1
  } wid_mode_e;
endpackage

// ---- rtl/wid_chg_detect.sv ----
// Port input change detector against the last software read
`timescale 1ns/1ps
module wid_chg_detect #(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Port pins
  input wire logic [PORT_W-1:0] pins,
  // Dispatcher side
  wid_chg_if.det link
);
  typedef struct packed {
    logic [PORT_W-1:0] snap;
    logic differ;
    logic change;
  } wid_det_s;

  wid_det_s s;
  wid_det_s next_s;

  always_comb begin
    next_s = s;
    // Reading the port re-arms the compare
    if (link.snap) begin
      next_s.snap = pins;
      next_s.differ = 1'b0;
      next_s.change = 1'b0;
    end else begin
      next_s.differ = (pins != s.snap);
      // One pulse per departure from the read value
      next_s.change = next_s.differ & ~s.differ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.change = s.change;

  a_snap_clears: assert property (@(posedge clk) disable iff (rst)
    link.snap |=> !link.change)
    else $error("change pulse right after a port read");
endmodule

// ---- rtl/wid_dispatch.sv ----
// Wake-up and interrupt dispatch with AXI4-Lite registers
`timescale 1ns/1ps
module wid_dispatch #(
  parameter int PORT_W = 8
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Event sources
  input wire logic EXT_INT,
  input wire logic [PORT_W-1:0] PORT_IN,
  input wire logic TIMER_OVF,
  input wire logic CONV_DONE,
  // Core and peripheral control
  output logic SLEEPING,
  output logic CLK_RUN,
  output logic CONV_RUN,
  output logic CONV_ABORT,
  output logic WAKE,
  output logic RESUME,
  output logic IRQ_VALID,
  output logic [7:0] IRQ_VECTOR,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import wid_pkg::*;

  typedef struct packed {
    wid_mode_e mode;
    logic glb;
    logic [7:0] ien;
    logic [7:0] wen;
    logic [7:0] flg;
    logic conv_run;
    logic conv_abort;
    logic clk_run;
    logic wake;
    logic resume;
    logic irq_valid;
    logic [7:0] vector;
    logic ext_q;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } wid_state_s;

  wid_state_s s;
  wid_state_s next_s;
  wid_chg_if chg ();

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_IRQ_EN) || (a == ADDR_WAKE_EN) || (a == ADDR_FLAGS)
      || (a == ADDR_STATUS) || (a == ADDR_CMD);
  endfunction

  logic asleep;
  logic ev_ext;
  logic ev_chg;
  logic ev_tov;
  logic ev_conv;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic [7:0] clr;
  logic [7:0] cmd;

  assign asleep = (s.mode == WID_SLEEP);
  assign ev_ext = EXT_INT & ~s.ext_q;
  assign ev_chg = chg.change;
  assign ev_tov = TIMER_OVF;
  assign ev_conv = CONV_DONE;
  // Address and data are taken together, so no skid storage is needed
  assign wr_fire = AWVALID & WVALID & ~s.bvalid;
  assign rd_fire = ARVALID & ~s.rvalid;
  assign wbyte = WSTRB[0] ? WDATA[7:0] : 8'h00;
  assign clr = (wr_fire && AWADDR == ADDR_FLAGS) ? wbyte : 8'h00;
  assign cmd = (wr_fire && AWADDR == ADDR_CMD) ? wbyte : 8'h00;
  assign chg.snap = cmd[CMD_PORT_READ];

  wid_chg_detect #(
    .PORT_W(PORT_W)
  ) u_detect (
    .clk(CORE_CLK),
    .rst(RST),
    .pins(PORT_IN),
    .link(chg.det)
  );

  always_comb begin
    logic [7:0] set;
    logic branch;
    logic wake_now;
    logic [7:0] vec;
    set = 8'h00;
    branch = 1'b0;
    wake_now = 1'b0;
    vec = RST_VECTOR;
    next_s = s;
    next_s.ext_q = EXT_INT;
    next_s.wake = 1'b0;
    next_s.resume = 1'b0;
    next_s.irq_valid = 1'b0;
    next_s.conv_abort = 1'b0;

    if (!asleep) begin
      // Flags only follow enabled sources
      set[BIT_EXT] = ev_ext & s.ien[BIT_EXT];
      set[BIT_CHG] = ev_chg & s.ien[BIT_CHG];
      set[BIT_TOV] = ev_tov & s.ien[BIT_TOV];
      set[BIT_CONV] = ev_conv & s.ien[BIT_CONV];
      // Lower vector wins; the others stay pending as flags
      if (set[BIT_EXT]) begin
        vec = VEC_EXT;
      end else if (set[BIT_CHG]) begin
        vec = VEC_CHG;
      end else if (set[BIT_TOV]) begin
        vec = VEC_TOV;
      end else if (set[BIT_CONV]) begin
        vec = VEC_CONV;
      end
      branch = s.glb & (set != 8'h00);
      if (ev_conv) begin
        next_s.conv_run = 1'b0;
      end
      if (cmd[CMD_CONV_START]) begin
        next_s.conv_run = 1'b1;
      end
      if (cmd[CMD_SLEEP]) begin
        next_s.mode = WID_SLEEP;
        // Converter cannot finish without its wake enable
        if (s.conv_run && !s.wen[BIT_WAKE_CONV]) begin
          next_s.conv_run = 1'b0;
          next_s.conv_abort = 1'b1;
          set[BIT_CONV] = s.ien[BIT_CONV];
        end
      end
    end else begin
      // External pin and timer sources are dead while asleep; port change stays live
      set[BIT_CHG] = ev_chg & s.ien[BIT_CHG];
      set[BIT_CONV] = ev_conv & s.wen[BIT_WAKE_CONV] & s.ien[BIT_CONV];
      if (ev_chg && s.wen[BIT_WAKE_CHG]) begin
        wake_now = 1'b1;
        if (s.glb && s.ien[BIT_CHG]) begin
          vec = VEC_CHG;
        end
      end
      if (ev_conv && s.wen[BIT_WAKE_CONV]) begin
        wake_now = 1'b1;
        next_s.conv_run = 1'b0;
        if (s.glb && s.ien[BIT_CONV] && vec == RST_VECTOR) begin
          vec = VEC_CONV;
        end
      end
      if (wake_now) begin
        next_s.mode = WID_NORMAL;
        next_s.wake = 1'b1;
      end
      branch = wake_now & (vec != RST_VECTOR);
      next_s.resume = wake_now & ~branch;
    end

    // A set in the clearing cycle wins
    next_s.flg = (s.flg & ~clr) | set;
    if (branch) begin
      next_s.irq_valid = 1'b1;
      next_s.vector = vec;
    end
    if (cmd[CMD_GLB_ON]) begin
      next_s.glb = 1'b1;
    end
    if (cmd[CMD_GLB_OFF]) begin
      next_s.glb = 1'b0;
    end
    // Oscillator only runs in sleep while the conversion wake is enabled
    next_s.clk_run = (next_s.mode == WID_NORMAL) | next_s.wen[BIT_WAKE_CONV];

    // Write channel
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(AWADDR) ? RESP_OKAY : RESP_SLVERR;
      if (AWADDR == ADDR_IRQ_EN && WSTRB[0]) begin
        next_s.ien = WDATA[7:0];
      end
      if (AWADDR == ADDR_WAKE_EN && WSTRB[0]) begin
        next_s.wen = WDATA[7:0];
      end
      if (cmd[CMD_SLEEP] || cmd[CMD_GLB_ON] || cmd[CMD_GLB_OFF]) begin
        next_s.clk_run = (next_s.mode == WID_NORMAL) | next_s.wen[BIT_WAKE_CONV];
      end
    end else if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire && AWADDR == ADDR_WAKE_EN && WSTRB[0]) begin
      next_s.clk_run = (next_s.mode == WID_NORMAL) | next_s.wen[BIT_WAKE_CONV];
    end

    // Read channel
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR)
        ADDR_IRQ_EN: begin
          next_s.rdata = {24'h000000, s.ien};
        end
        ADDR_WAKE_EN: begin
          next_s.rdata = {24'h000000, s.wen};
        end
        ADDR_FLAGS: begin
          next_s.rdata = {24'h000000, s.flg};
        end
        ADDR_STATUS: begin
          next_s.rdata = 32'h00000000;
          next_s.rdata[ST_ASLEEP] = asleep;
          next_s.rdata[ST_GLB] = s.glb;
          next_s.rdata[ST_CONV_RUN] = s.conv_run;
          next_s.rdata[ST_VEC_LSB +: 8] = s.vector;
        end
        default: begin
          next_s.rdata = 32'h00000000;
        end
      endcase
    end else if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.mode <= WID_NORMAL;
      s.ien <= RST_IRQ_EN;
      s.wen <= RST_WAKE_EN;
      s.flg <= RST_FLAGS;
      s.vector <= RST_VECTOR;
      s.clk_run <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign SLEEPING = asleep;
  assign CLK_RUN = s.clk_run;
  assign CONV_RUN = s.conv_run;
  assign CONV_ABORT = s.conv_abort;
  assign WAKE = s.wake;
  assign RESUME = s.resume;
  assign IRQ_VALID = s.irq_valid;
  assign IRQ_VECTOR = s.vector;
  assign AWREADY = wr_fire;
  assign WREADY = wr_fire;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = rd_fire;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = s.rdata;

  a_ext_flag_only: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && ev_ext && s.ien[BIT_EXT] && !s.glb |=> s.flg[BIT_EXT] && !IRQ_VALID)
    else $error("ext event without global should only flag");
  a_ext_vector: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && ev_ext && s.ien[BIT_EXT] && s.glb |=> IRQ_VALID && IRQ_VECTOR == VEC_EXT)
    else $error("ext event did not branch to its vector");
  a_ext_no_wake: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_ext && !ev_chg && !ev_conv |=> !WAKE && $stable(s.flg[BIT_EXT]))
    else $error("ext pin acted during sleep");
  a_chg_stay_asleep: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_chg && !s.wen[BIT_WAKE_CHG] && !ev_conv && !cmd[CMD_SLEEP] |=> asleep && !WAKE)
    else $error("port change woke without wake enable");
  a_sleep_clk_stop: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && !s.wen[BIT_WAKE_CONV] |-> !CLK_RUN)
    else $error("clocks running in plain sleep");
  a_chg_sleep_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_chg && s.ien[BIT_CHG] |=> s.flg[BIT_CHG])
    else $error("change flag not set in sleep");
  a_chg_wake_next: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_chg && s.wen[BIT_WAKE_CHG] && !(s.glb && s.ien[BIT_CHG]) && !ev_conv
    |=> WAKE && RESUME && !IRQ_VALID ##1 !WAKE)
    else $error("change wake without resume at next instruction");
  a_chg_wake_vec: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_chg && s.wen[BIT_WAKE_CHG] && s.ien[BIT_CHG] && s.glb
    |=> WAKE && IRQ_VALID && IRQ_VECTOR == VEC_CHG && s.flg[BIT_CHG])
    else $error("change wake did not vector");
  a_chg_norm_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && ev_chg && !s.ien[BIT_CHG] && !ev_ext && !ev_tov && !ev_conv |=> !IRQ_VALID)
    else $error("disabled change interrupted");
  a_tov_vector: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && ev_tov && s.ien[BIT_TOV] && s.glb && !(ev_ext && s.ien[BIT_EXT])
    && !(ev_chg && s.ien[BIT_CHG]) |=> IRQ_VALID && IRQ_VECTOR == VEC_TOV && s.flg[BIT_TOV])
    else $error("timer overflow vector wrong");
  a_conv_abort: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && cmd[CMD_SLEEP] && s.conv_run && !s.wen[BIT_WAKE_CONV]
    |=> CONV_ABORT && !CONV_RUN && s.flg[BIT_CONV] == $past(s.ien[BIT_CONV]))
    else $error("converter not stopped at sleep");
  a_conv_wake_vec: assert property (@(posedge CORE_CLK) disable iff (RST)
    asleep && ev_conv && s.wen[BIT_WAKE_CONV] && s.ien[BIT_CONV] && s.glb && !ev_chg
    |=> WAKE && IRQ_VALID && IRQ_VECTOR == VEC_CONV && s.flg[BIT_CONV])
    else $error("conversion wake did not vector");
  a_conv_norm_vec: assert property (@(posedge CORE_CLK) disable iff (RST)
    !asleep && ev_conv && s.ien[BIT_CONV] && s.glb && !(ev_ext && s.ien[BIT_EXT])
    && !(ev_chg && s.ien[BIT_CHG]) && !(ev_tov && s.ien[BIT_TOV])
    |=> IRQ_VALID && IRQ_VECTOR == VEC_CONV)
    else $error("conversion vector wrong");
  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    s.flg[BIT_CHG] && !clr[BIT_CHG] |=> s.flg[BIT_CHG])
    else $error("change flag dropped without clear");
endmodule
